// >>> sim/rdp_meas_model.sv
// Model of the phase and residual current channels feeding the stage
`timescale 1ns/1ps
`default_nettype none
module rdp_meas_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic signed [15:0] ph_set,
	input wire logic signed [15:0] ra_set,
	input wire logic signed [15:0] rb_set,
	output logic signed [15:0] pa_re,
	output logic signed [15:0] pa_im,
	output logic signed [15:0] pb_re,
	output logic signed [15:0] pb_im,
	output logic signed [15:0] pc_re,
	output logic signed [15:0] pc_im,
	output logic signed [15:0] ra_re,
	output logic signed [15:0] ra_im,
	output logic signed [15:0] rb_re,
	output logic signed [15:0] rb_im
);
	// Real parts of phase A and both residuals refresh every clock, all other parts are held at zero; a single loaded phase keeps magnitudes exact
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pa_re <= 16'sh0000;
			ra_re <= 16'sh0000;
			rb_re <= 16'sh0000;
		end
		else
		begin
			pa_re <= ph_set;
			ra_re <= ra_set;
			rb_re <= rb_set;
		end
	end
	assign pa_im = 16'sh0000;
	assign pb_re = 16'sh0000;
	assign pb_im = 16'sh0000;
	assign pc_re = 16'sh0000;
	assign pc_im = 16'sh0000;
	assign ra_im = 16'sh0000;
	assign rb_im = 16'sh0000;
endmodule // rdp_meas_model
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the residual differential stage
`include "rdp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rdp_pkg::*;
	localparam int CYC = 20;
	logic clk, rst_n, block_in, wr, rd, trip, blocked, irq;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, ev_time, rv;
	logic [3:0] ev_pulse;
	logic signed [15:0] ph_set, ra_set, rb_set;
	logic signed [15:0] pa_re, pa_im, pb_re, pb_im, pc_re, pc_im;
	logic signed [15:0] ra_re, ra_im, rb_re, rb_im;
	int n_mismatch, n_tests;
	int ev_cnt [4];
	int ev_base [4];

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
			if (ev_pulse[i] === 1'b1)
				ev_cnt[i]++;
	end

	rdp_meas_model i_rdp_meas_model (.clk(clk), .rst_n(rst_n),
		.ph_set(ph_set), .ra_set(ra_set), .rb_set(rb_set),
		.pa_re(pa_re), .pa_im(pa_im), .pb_re(pb_re), .pb_im(pb_im),
		.pc_re(pc_re), .pc_im(pc_im), .ra_re(ra_re), .ra_im(ra_im),
		.rb_re(rb_re), .rb_im(rb_im));

	rdp_stage #(.CYCLE_CLKS(CYC), .MS_CLKS(4)) i_rdp_stage (.clk(clk),
		.rst_n(rst_n), .phase_a_current_re(pa_re),
		.phase_a_current_im(pa_im), .phase_b_current_re(pb_re),
		.phase_b_current_im(pb_im), .phase_c_current_re(pc_re),
		.phase_c_current_im(pc_im), .residual_input_a_re(ra_re),
		.residual_input_a_im(ra_im), .residual_input_b_re(rb_re),
		.residual_input_b_im(rb_im), .block_in(block_in), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trip(trip),
		.blocked(blocked), .ev_pulse(ev_pulse), .ev_time(ev_time),
		.irq(irq));

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bw(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic br(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Two program ticks plus the blocking synchroniser delay
	task automatic settle;
		repeat (2 * CYC + 6) @(posedge clk);
		#1;
	endtask

	task automatic apply(input logic signed [15:0] p, a, b);
		@(posedge clk);
		ph_set <= p;
		ra_set <= a;
		rb_set <= b;
		settle;
	endtask

	task automatic evk(input int d0, d1, d2, d3);
		int d [4] = '{d0, d1, d2, d3};
		for (int i = 0; i < 4; i++)
		begin
			chk("event count", 32'(d[i]), 32'(ev_cnt[i] - ev_base[i]));
			ev_base[i] = ev_cnt[i];
		end
	endtask

	task automatic t_reset;
		logic [4:0] ad [10] = '{`RDP_A_CTRL, `RDP_A_PICKUP,
			`RDP_A_FIRST_TURN, `RDP_A_FIRST_SLOPE, `RDP_A_SECOND_TURN,
			`RDP_A_SECOND_SLOPE, `RDP_A_EVSEL, `RDP_A_IRQEN,
			`RDP_A_STATUS, 5'h1f};
		logic [31:0] ex [10] = '{32'h0, 32'h0a, 32'h64, 32'h3e8, 32'h12c,
			32'hfa0, 32'hf, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 10; i++)
		begin
			br(ad[i], rv);
			chk("reset value", ex[i], rv);
		end
	endtask

	task automatic t_trip;
		bw(`RDP_A_IRQCLR, 32'hf);
		bw(`RDP_A_IRQEN, 32'h1);
		apply(200, 0, 0);
		chk("trip", 32'h1, {31'h0, trip});
		evk(1, 0, 0, 0);
		br(`RDP_A_TIME, rv);
		chk("event stamp", 32'h1, {31'h0, ev_time <= rv && rv - ev_time < 32'd16});
		br(`RDP_A_STATUS, rv);
		chk("condition", 32'h1, {30'h0, rv[1:0]});
		br(`RDP_A_TRIPCNT, rv);
		chk("trip count", 32'h1, rv);
		chk("irq", 32'h1, {31'h0, irq});
		br(`RDP_A_IRQSTAT, rv);
		chk("irq status", 32'h1, rv);
		bw(`RDP_A_IRQEN, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		bw(`RDP_A_IRQCLR, 32'h1);
		bw(`RDP_A_IRQEN, 32'h1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apply(0, 0, 0);
		chk("trip released", 32'h0, {31'h0, trip});
		evk(0, 1, 0, 0);
		bw(`RDP_A_EVSEL, 32'h0);
		apply(200, 0, 0);
		evk(0, 0, 0, 0);
		apply(0, 0, 0);
		bw(`RDP_A_EVSEL, 32'hf);
		evk(0, 0, 0, 0);
	endtask

	task automatic t_block;
		apply(200, 0, 0);
		evk(1, 0, 0, 0);
		@(posedge clk);
		block_in <= 1'b1;
		settle;
		chk("trip", 32'h0, {31'h0, trip});
		chk("blocked", 32'h1, {31'h0, blocked});
		evk(0, 1, 1, 0);
		br(`RDP_A_STATUS, rv);
		chk("status", 32'h102, {23'h0, rv[8], 6'h0, rv[1:0]});
		apply(0, 0, 0);
		evk(0, 0, 0, 1);
		apply(200, 0, 0);
		chk("trip", 32'h0, {31'h0, trip});
		chk("blocked", 32'h1, {31'h0, blocked});
		evk(0, 0, 1, 0);
		br(`RDP_A_BLKCNT, rv);
		chk("blocked count", 32'h2, rv);
		@(posedge clk);
		block_in <= 1'b0;
		apply(0, 0, 0);
		evk(0, 0, 0, 1);
		bw(`RDP_A_CMD, 32'h2);
		br(`RDP_A_TRIPCNT, rv);
		chk("trip count", 32'h0, rv);
		br(`RDP_A_BLKCNT, rv);
		chk("blocked count", 32'h0, rv);
	endtask

	task automatic t_modes;
		logic [1:0] c;
		for (int m = 0; m < 5; m++)
		begin
			bw(`RDP_A_CTRL, 32'(m) << 4);
			apply(200, 0, 0);
			c = (m == 4) ? 2'd0 : (m % 2 == 1) ? 2'd2 : 2'd1;
			br(`RDP_A_STATUS, rv);
			chk("mode", 32'(m), {29'h0, rv[4:2]});
			chk("condition", {30'h0, c}, {30'h0, rv[1:0]});
			chk("trip", {31'h0, c == 2'd1}, {31'h0, trip});
			apply(0, 0, 0);
			evk(c == 1, c == 1, c == 2, c == 2);
		end
		bw(`RDP_A_CTRL, 32'h0);
	endtask

	task automatic t_chars;
		int tb_rows [11][5] = '{'{0, 200, -200, 0, 0}, '{2, 200, 200, 0, 0},
			'{2, 200, -200, 0, 1}, '{8, 200, 0, -200, 0},
			'{8, 200, -200, 0, 1}, '{0, 1000, -700, 0, 1},
			'{4, 1000, -700, 0, 0}, '{0, 1000, -800, 0, 0},
			'{0, 24, 0, 0, 1}, '{0, 300, -260, 0, 1}, '{0, 300, -280, 0, 0}};
		for (int i = 0; i < 11; i++)
		begin
			bw(`RDP_A_CTRL, 32'(tb_rows[i][0]));
			apply(16'(tb_rows[i][1]), 16'(tb_rows[i][2]), 16'(tb_rows[i][3]));
			chk("trip", 32'(tb_rows[i][4]), {31'h0, trip});
			apply(0, 0, 0);
		end
		apply(10, 0, 0);
		chk("trip at pick-up", 32'h0, {31'h0, trip});
		apply(0, 0, 0);
		bw(`RDP_A_CTRL, 32'h0);
		evk(5, 5, 0, 0);
	endtask

	task automatic t_comp;
		apply(30, 0, 0);
		bw(`RDP_A_CMD, 32'h1);
		settle;
		chk("trip ref", 32'h1, {31'h0, trip});
		bw(`RDP_A_CTRL, 32'h1);
		settle;
		chk("no offset from ref", 32'h1, {31'h0, trip});
		bw(`RDP_A_CMD, 32'h1);
		settle;
		chk("trip ced", 32'h0, {31'h0, trip});
		bw(`RDP_A_CTRL, 32'h0);
		settle;
		chk("trip ref again", 32'h1, {31'h0, trip});
		apply(0, 0, 0);
		evk(2, 2, 0, 0);
	endtask

	task automatic t_rec;
		logic [31:0] w0;
		logic [3:0] s;
		int fl [4] = '{2, 3, 8, 10};
		int fe [4] = '{100, 200, 200, 3};
		bw(`RDP_A_CTRL, 32'h300);
		br(`RDP_A_RECPTR, w0);
		repeat (13)
		begin
			apply(200, 0, 0);
			apply(0, 0, 0);
		end
		br(`RDP_A_RECPTR, rv);
		chk("record pointer", (w0 + 13) % 12, rv);
		s = 4'((w0 + 12) % 12);
		for (int i = 0; i < 4; i++)
		begin
			bw(`RDP_A_RECSEL, {24'h0, 4'(fl[i]), s});
			br(`RDP_A_RECDATA, rv);
			chk("record field", 32'(fe[i]), rv);
		end
		bw(`RDP_A_CTRL, 32'h0);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		block_in = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		ph_set = 16'sh0000;
		ra_set = 16'sh0000;
		rb_set = 16'sh0000;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_trip;
		t_block;
		t_modes;
		t_chars;
		t_comp;
		t_rec;
		print_verdict;
	end

	// Whole sequence needs about 3700 clocks
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict;
	end
endmodule // tb
`default_nettype wire

// >>> src/rdp_map.svh
// Register map, field positions, reset values and timing for the stage
`ifndef RDP_MAP_SVH
`define RDP_MAP_SVH

`define RDP_CLK_NS 50
`define RDP_CYCLE_NS 5000000
`define RDP_MS_NS 1000000

`define RDP_A_CTRL 5'h00
`define RDP_A_PICKUP 5'h01
`define RDP_A_FIRST_TURN 5'h02
`define RDP_A_FIRST_SLOPE 5'h03
`define RDP_A_SECOND_TURN 5'h04
`define RDP_A_SECOND_SLOPE 5'h05
`define RDP_A_CMD 5'h06
`define RDP_A_STATUS 5'h07
`define RDP_A_TRIPCNT 5'h08
`define RDP_A_BLKCNT 5'h09
`define RDP_A_EVSEL 5'h0a
`define RDP_A_IRQSTAT 5'h0b
`define RDP_A_IRQCLR 5'h0c
`define RDP_A_IRQEN 5'h0d
`define RDP_A_RECSEL 5'h0e
`define RDP_A_RECDATA 5'h0f
`define RDP_A_RECPTR 5'h10
`define RDP_A_TIME 5'h11

`define RDP_CTRL_CABLE_END 0
`define RDP_CTRL_SUB 1
`define RDP_CTRL_BMAX 2
`define RDP_CTRL_INB 3
`define RDP_CTRL_MODE 6:4
`define RDP_CTRL_GRP 10:8
`define RDP_CMD_COMP 0
`define RDP_CMD_CLR 1

`define RDP_RST_CTRL 11'h000
`define RDP_RST_PICKUP 16'h000a
`define RDP_RST_FIRST_TURN 16'h0064
`define RDP_RST_FIRST_SLOPE 16'h03e8
`define RDP_RST_SECOND_TURN 16'h012c
`define RDP_RST_SECOND_SLOPE 16'h0fa0
`define RDP_RST_EVSEL 4'hf
`define RDP_SLOPE_DIV 36'h000002710

`define RDP_NREC 12
`define RDP_NFLD 11
`define RDP_EV_TRIP_ON 0
`define RDP_EV_TRIP_OFF 1
`define RDP_EV_BLK_ON 2
`define RDP_EV_BLK_OFF 3

`endif

// >>> src/rdp_pkg.sv
// Types shared by the residual differential stage
package rdp_pkg;
	typedef enum logic [1:0] {
		RDP_NORMAL = 2'b00,
		RDP_TRIP = 2'b01,
		RDP_BLOCKED = 2'b10
	} rdp_cond_t;
	typedef enum logic [2:0] {
		RDP_ON = 3'b000,
		RDP_MBLOCKED = 3'b001,
		RDP_TEST = 3'b010,
		RDP_TEST_BLOCKED = 3'b011,
		RDP_OFF = 3'b100
	} rdp_mode_t;
	typedef logic signed [19:0] rdp_cplx_t;
	typedef logic [19:0] rdp_mag_t;
endpackage

// >>> src/rdp_stage.sv
// Residual-current differential protection stage with record store
//
// The plain strobed port and the placing of the registers were left to the implementer.
`include "rdp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rdp_stage #(
	parameter int CYCLE_CLKS = `RDP_CYCLE_NS / `RDP_CLK_NS,
	parameter int MS_CLKS = `RDP_MS_NS / `RDP_CLK_NS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic signed [15:0] phase_a_current_re,
	input wire logic signed [15:0] phase_a_current_im,
	input wire logic signed [15:0] phase_b_current_re,
	input wire logic signed [15:0] phase_b_current_im,
	input wire logic signed [15:0] phase_c_current_re,
	input wire logic signed [15:0] phase_c_current_im,
	input wire logic signed [15:0] residual_input_a_re,
	input wire logic signed [15:0] residual_input_a_im,
	input wire logic signed [15:0] residual_input_b_re,
	input wire logic signed [15:0] residual_input_b_im,
	input wire logic block_in,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic trip,
	output logic blocked,
	output logic [3:0] ev_pulse,
	output logic [31:0] ev_time,
	output logic irq
);
	import rdp_pkg::*;

	function automatic rdp_mag_t mag(input rdp_cplx_t re, input rdp_cplx_t im);
		rdp_mag_t a;
		rdp_mag_t b;
		a = re[19] ? rdp_mag_t'(-re) : rdp_mag_t'(re);
		b = im[19] ? rdp_mag_t'(-im) : rdp_mag_t'(im);
		mag = (a > b) ? a + (b >> 1) : b + (a >> 1);
	endfunction

	function automatic rdp_mag_t max2(input rdp_mag_t a, input rdp_mag_t b);
		max2 = (a > b) ? a : b;
	endfunction

	logic [31:0] div_q;
	logic [31:0] ms_div_q;
	logic [31:0] time_q;
	logic tick;
	logic [10:0] ctrl_q;
	logic [15:0] pickup_q, first_turn_q, first_slope_q;
	logic [15:0] second_turn_q, second_slope_q;
	logic [3:0] evsel_q, irq_stat_q, irq_en_q;
	logic [15:0] trip_cnt_q, blk_cnt_q;
	logic [7:0] recsel_q;
	logic [3:0] wptr_q;
	logic [31:0] rec_q [`RDP_NREC][`RDP_NFLD];
	logic bs1_q, bs2_q, bs3_q, blk_lvl_q, blk_smp_q;
	logic pu_q;
	rdp_cond_t cond_q, cond_d;
	rdp_cplx_t off_re_q, off_im_q;
	rdp_mag_t max_bias_q, max_diff_q, max_char_q;
	logic [3:0] ev_raw;
	rdp_mode_t mode;
	logic cmd_wr, off, blk_eff;

	assign cmd_wr = wr && addr == `RDP_A_CMD;
	assign mode = rdp_mode_t'(ctrl_q[`RDP_CTRL_MODE]);
	assign off = mode == RDP_OFF;
	assign tick = div_q == 32'(CYCLE_CLKS - 1);

	// Program cycle and millisecond time base
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			div_q <= 32'h0;
		else
			div_q <= tick ? 32'h0 : div_q + 32'h1;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			ms_div_q <= 32'h0;
			time_q <= 32'h0;
		end
		else if (ms_div_q == 32'(MS_CLKS - 1))
		begin
			ms_div_q <= 32'h0;
			time_q <= time_q + 32'h1;
		end
		else
			ms_div_q <= ms_div_q + 32'h1;

	// Phasor arithmetic
	rdp_cplx_t ps_re, ps_im, res_re, res_im, calc_re, calc_im, d_re, d_im;
	rdp_mag_t m_calc, m_res, m_diff, m_bias, m_char, m_pha, m_phb, m_phc;
	logic [35:0] seg1, seg2;
	rdp_mag_t first_turn_m, second_turn_m;

	always_comb
	begin
		ps_re = rdp_cplx_t'(phase_a_current_re) + rdp_cplx_t'(phase_b_current_re)
			+ rdp_cplx_t'(phase_c_current_re);
		ps_im = rdp_cplx_t'(phase_a_current_im) + rdp_cplx_t'(phase_b_current_im)
			+ rdp_cplx_t'(phase_c_current_im);
		res_re = ctrl_q[`RDP_CTRL_INB] ? rdp_cplx_t'(residual_input_b_re)
			: rdp_cplx_t'(residual_input_a_re);
		res_im = ctrl_q[`RDP_CTRL_INB] ? rdp_cplx_t'(residual_input_b_im)
			: rdp_cplx_t'(residual_input_a_im);
		calc_re = ctrl_q[`RDP_CTRL_CABLE_END] ? ps_re - off_re_q : ps_re;
		calc_im = ctrl_q[`RDP_CTRL_CABLE_END] ? ps_im - off_im_q : ps_im;
		d_re = ctrl_q[`RDP_CTRL_SUB] ? calc_re - res_re : calc_re + res_re;
		d_im = ctrl_q[`RDP_CTRL_SUB] ? calc_im - res_im : calc_im + res_im;
		m_calc = mag(calc_re, calc_im);
		m_res = mag(res_re, res_im);
		m_diff = mag(d_re, d_im);
		m_pha = mag(rdp_cplx_t'(phase_a_current_re), rdp_cplx_t'(phase_a_current_im));
		m_phb = mag(rdp_cplx_t'(phase_b_current_re), rdp_cplx_t'(phase_b_current_im));
		m_phc = mag(rdp_cplx_t'(phase_c_current_re), rdp_cplx_t'(phase_c_current_im));
		if (ctrl_q[`RDP_CTRL_BMAX])
			m_bias = max2(max2(m_pha, m_phb), max2(m_phc, m_res));
		else
			m_bias = rdp_mag_t'(({1'b0, m_calc} + {1'b0, m_res}) >> 1);
		first_turn_m = rdp_mag_t'(first_turn_q);
		second_turn_m = rdp_mag_t'(second_turn_q);
		seg1 = 36'h0;
		seg2 = 36'h0;
		if (m_bias > first_turn_m)
			seg1 = (36'(((m_bias < second_turn_m) ? m_bias : second_turn_m)
				- first_turn_m) * 36'(first_slope_q)) / `RDP_SLOPE_DIV;
		if (m_bias > second_turn_m && second_turn_m > first_turn_m)
			seg2 = (36'(m_bias - second_turn_m) * 36'(second_slope_q))
				/ `RDP_SLOPE_DIV;
		m_char = rdp_mag_t'(seg1 + seg2 + 36'(pickup_q));
	end

	// Blocking pin synchroniser; level counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			bs1_q <= 1'b0;
			bs2_q <= 1'b0;
			bs3_q <= 1'b0;
			blk_lvl_q <= 1'b0;
		end
		else
		begin
			bs1_q <= block_in;
			bs2_q <= bs1_q;
			bs3_q <= bs2_q;
			if (bs2_q == bs3_q)
				blk_lvl_q <= bs3_q;
		end

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			blk_smp_q <= 1'b0;
		else if (tick)
			blk_smp_q <= blk_lvl_q;

	assign blk_eff = blk_lvl_q || mode == RDP_MBLOCKED || mode == RDP_TEST_BLOCKED;

	// Pick-up element
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			pu_q <= 1'b0;
		else if (tick)
			pu_q <= !off && m_diff > m_char;

	// Condition state machine, evaluated once per program cycle
	logic pu_now;
	assign pu_now = !off && m_diff > m_char;

	always_comb
	begin
		cond_d = cond_q;
		ev_raw = 4'h0;
		if (tick)
		begin
			case (cond_q)
				RDP_NORMAL:
					if (off)
						cond_d = RDP_NORMAL;
					else if (pu_now && blk_eff)
					begin
						cond_d = RDP_BLOCKED;
						ev_raw[`RDP_EV_BLK_ON] = 1'b1;
					end
					else if (pu_now)
					begin
						cond_d = RDP_TRIP;
						ev_raw[`RDP_EV_TRIP_ON] = 1'b1;
					end
				RDP_TRIP:
					if (!pu_now)
					begin
						cond_d = RDP_NORMAL;
						ev_raw[`RDP_EV_TRIP_OFF] = !off;
					end
					else if (blk_eff)
					begin
						cond_d = RDP_BLOCKED;
						ev_raw[`RDP_EV_TRIP_OFF] = 1'b1;
						ev_raw[`RDP_EV_BLK_ON] = 1'b1;
					end
				RDP_BLOCKED:
					if (!pu_now)
					begin
						cond_d = RDP_NORMAL;
						ev_raw[`RDP_EV_BLK_OFF] = !off;
					end
				default:
					cond_d = RDP_NORMAL;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cond_q <= RDP_NORMAL;
		else
			cond_q <= cond_d;

	assign trip = cond_q == RDP_TRIP;
	assign blocked = cond_q == RDP_BLOCKED;

	// Events to the buffer, gated per event by the selection
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			ev_pulse <= 4'h0;
			ev_time <= 32'h0;
		end
		else
		begin
			ev_pulse <= ev_raw & evsel_q;
			if (|ev_raw)
				ev_time <= time_q;
		end

	// Interrupt status: a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			irq_stat_q <= 4'h0;
		else if (wr && addr == `RDP_A_IRQCLR)
			irq_stat_q <= (irq_stat_q & ~wdata[3:0]) | ev_raw;
		else
			irq_stat_q <= irq_stat_q | ev_raw;

	assign irq = |(irq_stat_q & irq_en_q);

	// Cumulative counters
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			trip_cnt_q <= 16'h0;
			blk_cnt_q <= 16'h0;
		end
		else
		begin
			if (cmd_wr && wdata[`RDP_CMD_CLR])
			begin
				trip_cnt_q <= 16'h0;
				blk_cnt_q <= 16'h0;
			end
			if (ev_raw[`RDP_EV_TRIP_ON])
				trip_cnt_q <= trip_cnt_q + 16'h1;
			if (ev_raw[`RDP_EV_BLK_ON])
				blk_cnt_q <= blk_cnt_q + 16'h1;
		end

	// Running maxima for the present episode
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			max_bias_q <= '0;
			max_diff_q <= '0;
			max_char_q <= '0;
		end
		else if (tick)
		begin
			max_bias_q <= (cond_q == RDP_NORMAL) ? m_bias : max2(max_bias_q, m_bias);
			max_diff_q <= (cond_q == RDP_NORMAL) ? m_diff : max2(max_diff_q, m_diff);
			max_char_q <= (cond_q == RDP_NORMAL) ? m_char : max2(max_char_q, m_char);
		end

	// Record store: ring of twelve, written on each ON event
	logic rec_wr;
	assign rec_wr = ev_raw[`RDP_EV_TRIP_ON] || ev_raw[`RDP_EV_BLK_ON];

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			wptr_q <= 4'h0;
		else if (rec_wr)
			wptr_q <= (wptr_q == 4'(`RDP_NREC - 1)) ? 4'h0 : wptr_q + 4'h1;

	always_ff @(posedge clk)
		if (rec_wr)
		begin
			rec_q[wptr_q][0] <= time_q;
			rec_q[wptr_q][1] <= {28'h0, ev_raw};
			rec_q[wptr_q][2] <= 32'(m_bias);
			rec_q[wptr_q][3] <= 32'(m_diff);
			rec_q[wptr_q][4] <= 32'(m_char);
			rec_q[wptr_q][5] <= 32'(max2(max_bias_q, m_bias));
			rec_q[wptr_q][6] <= 32'(max2(max_diff_q, m_diff));
			rec_q[wptr_q][7] <= 32'(max2(max_char_q, m_char));
			rec_q[wptr_q][8] <= 32'(m_calc);
			rec_q[wptr_q][9] <= 32'(m_res);
			rec_q[wptr_q][10] <= {29'h0, ctrl_q[`RDP_CTRL_GRP]};
		end

	// Natural unbalance compensation
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			off_re_q <= '0;
			off_im_q <= '0;
		end
		else if (cmd_wr && wdata[`RDP_CMD_COMP] && ctrl_q[`RDP_CTRL_CABLE_END])
		begin
			off_re_q <= ps_re;
			off_im_q <= ps_im;
		end

	// Settings registers
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			ctrl_q <= `RDP_RST_CTRL;
			pickup_q <= `RDP_RST_PICKUP;
			first_turn_q <= `RDP_RST_FIRST_TURN;
			first_slope_q <= `RDP_RST_FIRST_SLOPE;
			second_turn_q <= `RDP_RST_SECOND_TURN;
			second_slope_q <= `RDP_RST_SECOND_SLOPE;
			evsel_q <= `RDP_RST_EVSEL;
			irq_en_q <= 4'h0;
			recsel_q <= 8'h0;
		end
		else if (wr)
		begin
			if (addr == `RDP_A_CTRL)
				ctrl_q <= wdata[10:0];
			else if (addr == `RDP_A_PICKUP)
				pickup_q <= wdata[15:0];
			else if (addr == `RDP_A_FIRST_TURN)
				first_turn_q <= wdata[15:0];
			else if (addr == `RDP_A_FIRST_SLOPE)
				first_slope_q <= wdata[15:0];
			else if (addr == `RDP_A_SECOND_TURN)
				second_turn_q <= wdata[15:0];
			else if (addr == `RDP_A_SECOND_SLOPE)
				second_slope_q <= wdata[15:0];
			else if (addr == `RDP_A_EVSEL)
				evsel_q <= wdata[3:0];
			else if (addr == `RDP_A_IRQEN)
				irq_en_q <= wdata[3:0];
			else if (addr == `RDP_A_RECSEL)
				recsel_q <= wdata[7:0];
		end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			rdata <= 32'h0;
		else if (rd)
		begin
			if (addr == `RDP_A_CTRL)
				rdata <= {21'h0, ctrl_q};
			else if (addr == `RDP_A_PICKUP)
				rdata <= {16'h0, pickup_q};
			else if (addr == `RDP_A_FIRST_TURN)
				rdata <= {16'h0, first_turn_q};
			else if (addr == `RDP_A_FIRST_SLOPE)
				rdata <= {16'h0, first_slope_q};
			else if (addr == `RDP_A_SECOND_TURN)
				rdata <= {16'h0, second_turn_q};
			else if (addr == `RDP_A_SECOND_SLOPE)
				rdata <= {16'h0, second_slope_q};
			else if (addr == `RDP_A_STATUS)
				rdata <= {23'h0, blk_smp_q, blocked, trip, pu_q, mode, cond_q};
			else if (addr == `RDP_A_TRIPCNT)
				rdata <= {16'h0, trip_cnt_q};
			else if (addr == `RDP_A_BLKCNT)
				rdata <= {16'h0, blk_cnt_q};
			else if (addr == `RDP_A_EVSEL)
				rdata <= {28'h0, evsel_q};
			else if (addr == `RDP_A_IRQSTAT)
				rdata <= {28'h0, irq_stat_q};
			else if (addr == `RDP_A_IRQEN)
				rdata <= {28'h0, irq_en_q};
			else if (addr == `RDP_A_RECSEL)
				rdata <= {24'h0, recsel_q};
			else if (addr == `RDP_A_RECDATA && recsel_q[3:0] < 4'(`RDP_NREC)
				&& recsel_q[7:4] < 4'(`RDP_NFLD))
				rdata <= rec_q[recsel_q[3:0]][recsel_q[7:4]];
			else if (addr == `RDP_A_RECPTR)
				rdata <= {28'h0, wptr_q};
			else if (addr == `RDP_A_TIME)
				rdata <= time_q;
			else
				rdata <= 32'h0;
		end

	// Checks
	property p_excl;
		@(posedge clk) disable iff (!rst_n) !(trip && blocked);
	endproperty
	a_excl: assert property (p_excl) else $error("trip and blocked together");

	property p_trip_on;
		@(posedge clk) disable iff (!rst_n)
		tick && cond_q == RDP_NORMAL && pu_now && !blk_eff |=> trip && !blocked;
	endproperty
	a_trip_on: assert property (p_trip_on) else $error("no trip on pick-up");

	property p_blk_on;
		@(posedge clk) disable iff (!rst_n)
		tick && cond_q == RDP_NORMAL && pu_now && blk_eff |=> blocked && !trip;
	endproperty
	a_blk_on: assert property (p_blk_on) else $error("no blocked output");

	property p_trip_rel;
		@(posedge clk) disable iff (!rst_n)
		tick && trip && blk_eff |=> !trip ##0 ev_pulse[`RDP_EV_TRIP_OFF] == evsel_q[1];
	endproperty
	a_trip_rel: assert property (p_trip_rel) else $error("trip not released");

	property p_blk_hold;
		@(posedge clk) disable iff (!rst_n) blocked && !tick |=> blocked;
	endproperty
	a_blk_hold: assert property (p_blk_hold) else $error("blocked left mid-cycle");

	property p_off;
		@(posedge clk) disable iff (!rst_n)
		off && !trip && !blocked |=> !trip && !blocked && ev_pulse == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("activity in off mode");

	property p_cnt;
		@(posedge clk) disable iff (!rst_n)
		$rose(trip) && !$past(cmd_wr) |-> trip_cnt_q == $past(trip_cnt_q) + 16'h1;
	endproperty
	a_cnt: assert property (p_cnt) else $error("trip count not advanced");

	property p_ring;
		@(posedge clk) disable iff (!rst_n)
		rec_wr && wptr_q == 4'hb |=> wptr_q == 4'h0;
	endproperty
	a_ring: assert property (p_ring) else $error("record ring wrap wrong");

	property p_pu;
		@(posedge clk) disable iff (!rst_n) tick |=> pu_q == $past(pu_now);
	endproperty
	a_pu: assert property (p_pu) else $error("pick-up mismatch");

	property p_irq;
		@(posedge clk) disable iff (!rst_n)
		|(ev_raw & irq_en_q) && !(wr && addr == `RDP_A_IRQEN) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("event lost on interrupt");

	c_trip: cover property (@(posedge clk) disable iff (!rst_n) $rose(trip));
	c_blk: cover property (@(posedge clk) disable iff (!rst_n) trip ##1 blocked);
	c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
		rec_wr && wptr_q == 4'hb);
endmodule // rdp_stage
`default_nettype wire
